// File: verilog/msr_pkg.sv
// constants shared by the memory controller status register bank
package msr_pkg;

	// data width of the register port
	localparam int DW = 32;
	// number of captured interrupt sources
	localparam int N_SRC = 3;
	// lane-map words: four data nibble groups plus the check-bit group
	localparam int N_LANE = 5;
	// general-purpose output words
	localparam int N_GP = 4;
	// least address width accepted; every offset below fits in it
	localparam int ADDR_W_MIN = 12;

	// register offsets, byte addresses
	localparam logic [11:0] OFF_TRAIN_REQ = 12'h378;
	localparam logic [11:0] OFF_UPD_REQ = 12'h37C;
	localparam logic [11:0] OFF_LANE_NIB_LO = 12'h380;
	localparam logic [11:0] OFF_LANE_NIB_MID_LO = 12'h384;
	localparam logic [11:0] OFF_LANE_NIB_MID_HI = 12'h388;
	localparam logic [11:0] OFF_LANE_NIB_HI = 12'h38C;
	localparam logic [11:0] OFF_LANE_CHECKBITS = 12'h390;
	localparam logic [11:0] OFF_RANK_MODE = 12'h398;
	localparam logic [11:0] OFF_SEQ_PROGRESS = 12'h39C;
	localparam logic [11:0] OFF_GP_INPUT = 12'h400;
	localparam logic [11:0] OFF_GP_OUT0 = 12'h408;
	localparam logic [11:0] OFF_GP_OUT1 = 12'h40C;
	localparam logic [11:0] OFF_GP_OUT2 = 12'h410;
	localparam logic [11:0] OFF_GP_OUT3 = 12'h414;
	localparam logic [11:0] OFF_IRQ_SETUP = 12'h500;
	localparam logic [11:0] OFF_IRQ_CLEAR = 12'h508;
	localparam logic [11:0] OFF_IRQ_RAW = 12'h510;
	localparam logic [11:0] OFF_SRAM_CORR_LO = 12'h518;
	localparam logic [11:0] OFF_SRAM_CORR_HI = 12'h51C;
	localparam logic [11:0] OFF_SRAM_DEFER_LO = 12'h520;
	localparam logic [11:0] OFF_SRAM_DEFER_HI = 12'h524;
	localparam logic [11:0] OFF_EXT_CORR_LO = 12'h528;

	// interrupt status bit positions
	localparam int IRQ_SRAM_CORR = 0;
	localparam int IRQ_SRAM_DEFER = 1;
	localparam int IRQ_EXT_CORR = 2;

	// reset value of every register in the bank
	localparam logic [31:0] RST_WORD = 32'h00000000;

endpackage

// File: verilog/msr_irq_if.sv
// carrier between the register bank and its interrupt collector
`timescale 1ns/100ps
`default_nettype none

interface msr_irq_if #(
	parameter int N = 3
);
	logic [N-1:0] evt;
	logic clr_wr;
	logic [N-1:0] clr_mask;
	logic [N-1:0] enable;
	logic [N-1:0] raw;
	logic irq;

	// bank side: drives events, clears and enables
	modport bank (
		output evt,
		output clr_wr,
		output clr_mask,
		output enable,
		input raw,
		input irq
	);

	// collector side: keeps the sticky bits and the interrupt level
	modport ctrl (
		input evt,
		input clr_wr,
		input clr_mask,
		input enable,
		output raw,
		output irq
	);
endinterface

`default_nettype wire

// File: verilog/msr_irq_ctrl.sv
// sticky interrupt status bits and the masked interrupt level
`timescale 1ns/100ps
`default_nettype none

module msr_irq_ctrl #(
	parameter int N = 3
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// bank connection
	msr_irq_if.ctrl irq_bus
);
	logic [N-1:0] raw_q;
	logic [N-1:0] raw_d;
	logic irq_q;

	// at least one source is needed
	if (N < 1) begin : g_bad_n
		$error("N must be at least one");
	end

	always_comb begin
		raw_d = raw_q & ~(irq_bus.clr_wr ? irq_bus.clr_mask : '0);
		raw_d = raw_d | irq_bus.evt; // a new event beats a clear
	end

	// sticky status bits
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			raw_q <= '0;
		end else begin
			raw_q <= raw_d;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(raw_d & irq_bus.enable);
		end
	end

	assign irq_bus.raw = raw_q;
	assign irq_bus.irq = irq_q;

	AST_SET_BEATS_CLEAR: assert property (@(posedge ref_clk) disable iff (!rstn)
		irq_bus.evt[0] |=> raw_q[0])
		else $error("event lost against a clear");

	AST_CLEAR_BY_ONE: assert property (@(posedge ref_clk) disable iff (!rstn)
		(irq_bus.clr_wr && irq_bus.clr_mask[0] && !irq_bus.evt[0]) |=> !raw_q[0])
		else $error("written one did not clear status bit");

	AST_ZERO_KEEPS: assert property (@(posedge ref_clk) disable iff (!rstn)
		(raw_q[0] && !(irq_bus.clr_wr && irq_bus.clr_mask[0])) |=> raw_q[0])
		else $error("status bit dropped without a clear");

	AST_IRQ_LEVEL: assert property (@(posedge ref_clk) disable iff (!rstn)
		##1 (irq_q == |(raw_q & $past(irq_bus.enable))))
		else $error("interrupt level disagrees with enabled status");

endmodule // msr_irq_ctrl

`default_nettype wire

// File: verilog/msr_regbank.sv
// register bank: request status, lane maps, general words, interrupts
//
// Summary of operation
// - status and capture registers always readable; writes to them are ignored.
// - read-write registers accept writes and read back stored value in any state.
// - training request status reads current pending and active requests; resets to zero.
// - update request status reads current update requests; resets to zero.
// - one lane-map index word per nibble group drives CRC compensation.
// - separate lane-map word drives CRC compensation of check-bit lanes.
// - rank state reads half-rate clocking, max power saving and latency settings.
// - sequence progress reads the mode-change sequence being processed now.
// - general input view reads the live general-purpose input word.
// - four output words each drive their own output, reset to zero.
// - interrupt setup register is read-write, resets to zero, steers interrupt output.
// - interrupt clear is write-only, always accepted, reads return zero.
// - raw interrupt state shows conditions before masking.
// - each SRAM error source captures event details in a 64-bit register pair; the external source in one 32-bit word.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module msr_regbank #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [msr_pkg::DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [msr_pkg::DW-1:0] reg_rdata,
	// live controller state
	input wire logic [msr_pkg::DW-1:0] train_req_state_i,
	input wire logic [msr_pkg::DW-1:0] upd_req_state_i,
	input wire logic [msr_pkg::DW-1:0] rank_mode_state_i,
	input wire logic [msr_pkg::DW-1:0] seq_progress_i,
	input wire logic [msr_pkg::DW-1:0] gp_input_i,
	// error events with their details
	input wire logic sram_corr_evt_i,
	input wire logic [63:0] sram_corr_info_i,
	input wire logic sram_defer_evt_i,
	input wire logic [63:0] sram_defer_info_i,
	input wire logic ext_corr_evt_i,
	input wire logic [msr_pkg::DW-1:0] ext_corr_info_i,
	// lane maps toward the CRC logic
	output logic [4*msr_pkg::DW-1:0] lane_map_nib_o,
	output logic [msr_pkg::DW-1:0] lane_map_chk_o,
	// general-purpose output words
	output logic [msr_pkg::N_GP*msr_pkg::DW-1:0] gp_output_o,
	// interrupt level
	output logic irq_o
);
	import msr_pkg::*;

	// address width must reach the top offset
	if (ADDR_W < ADDR_W_MIN) begin : g_bad_addr_w
		$error("ADDR_W too small for the register map");
	end

	// storage
	logic [DW-1:0] lane_map_q [N_LANE];
	logic [DW-1:0] gp_out_q [N_GP];
	logic [DW-1:0] irq_setup_q;
	logic [63:0] sram_corr_info_q;
	logic [63:0] sram_defer_info_q;
	logic [DW-1:0] ext_corr_info_q;
	logic [DW-1:0] rdata_q;
	logic [DW-1:0] rdata_d;
	logic [N_SRC-1:0] evt;

	msr_irq_if #(.N(N_SRC)) irq_bus ();

	// true when the port address selects a given offset
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
		return a == ADDR_W'(off);
	endfunction

	// index of a lane-map word, valid when in range
	function automatic logic [2:0] lane_idx(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] rel;
		rel = a - ADDR_W'(OFF_LANE_NIB_LO);
		return rel[4:2];
	endfunction

	// true when the address falls on a lane-map word
	function automatic logic lane_hit(input logic [ADDR_W-1:0] a);
		return a >= ADDR_W'(OFF_LANE_NIB_LO) && a <= ADDR_W'(OFF_LANE_CHECKBITS) && a[1:0] == 2'b00;
	endfunction

	// index of an output word, valid when in range
	function automatic logic [1:0] gp_idx(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] rel;
		rel = a - ADDR_W'(OFF_GP_OUT0);
		return rel[3:2];
	endfunction

	// true when the address falls on an output word
	function automatic logic gp_hit(input logic [ADDR_W-1:0] a);
		return a >= ADDR_W'(OFF_GP_OUT0) && a <= ADDR_W'(OFF_GP_OUT3) && a[1:0] == 2'b00;
	endfunction

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < N_LANE; i++) begin
				lane_map_q[i] <= RST_WORD;
			end
		end else if (reg_wr && lane_hit(reg_addr)) begin
			lane_map_q[lane_idx(reg_addr)] <= reg_wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < N_GP; i++) begin
				gp_out_q[i] <= RST_WORD;
			end
		end else if (reg_wr && gp_hit(reg_addr)) begin
			gp_out_q[gp_idx(reg_addr)] <= reg_wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			irq_setup_q <= RST_WORD;
		end else if (reg_wr && hit(reg_addr, OFF_IRQ_SETUP)) begin
			irq_setup_q <= reg_wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sram_corr_info_q <= {RST_WORD, RST_WORD};
			sram_defer_info_q <= {RST_WORD, RST_WORD};
			ext_corr_info_q <= RST_WORD;
		end else begin
			if (sram_corr_evt_i) begin
				sram_corr_info_q <= sram_corr_info_i;
			end
			if (sram_defer_evt_i) begin
				sram_defer_info_q <= sram_defer_info_i;
			end
			if (ext_corr_evt_i) begin
				ext_corr_info_q <= ext_corr_info_i;
			end
		end
	end

	// events and clears toward the collector
	always_comb begin
		evt = '0;
		evt[IRQ_SRAM_CORR] = sram_corr_evt_i;
		evt[IRQ_SRAM_DEFER] = sram_defer_evt_i;
		evt[IRQ_EXT_CORR] = ext_corr_evt_i;
	end

	assign irq_bus.evt = evt;
	assign irq_bus.clr_wr = reg_wr && hit(reg_addr, OFF_IRQ_CLEAR);
	assign irq_bus.clr_mask = reg_wdata[N_SRC-1:0];
	assign irq_bus.enable = irq_setup_q[N_SRC-1:0];

	msr_irq_ctrl #(.N(N_SRC)) u_irq (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.irq_bus(irq_bus.ctrl)
	);

	// read decode; unmapped and write-only offsets read zero
	always_comb begin
		rdata_d = RST_WORD;
		if (lane_hit(reg_addr)) begin
			rdata_d = lane_map_q[lane_idx(reg_addr)];
		end else if (gp_hit(reg_addr)) begin
			rdata_d = gp_out_q[gp_idx(reg_addr)];
		end else begin
			case (reg_addr)
				ADDR_W'(OFF_TRAIN_REQ): rdata_d = train_req_state_i;
				ADDR_W'(OFF_UPD_REQ): rdata_d = upd_req_state_i;
				ADDR_W'(OFF_RANK_MODE): rdata_d = rank_mode_state_i;
				ADDR_W'(OFF_SEQ_PROGRESS): rdata_d = seq_progress_i;
				ADDR_W'(OFF_GP_INPUT): rdata_d = gp_input_i;
				ADDR_W'(OFF_IRQ_SETUP): rdata_d = irq_setup_q;
				ADDR_W'(OFF_IRQ_RAW): rdata_d = {{(DW-N_SRC){1'b0}}, irq_bus.raw};
				ADDR_W'(OFF_SRAM_CORR_LO): rdata_d = sram_corr_info_q[31:0];
				ADDR_W'(OFF_SRAM_CORR_HI): rdata_d = sram_corr_info_q[63:32];
				ADDR_W'(OFF_SRAM_DEFER_LO): rdata_d = sram_defer_info_q[31:0];
				ADDR_W'(OFF_SRAM_DEFER_HI): rdata_d = sram_defer_info_q[63:32];
				ADDR_W'(OFF_EXT_CORR_LO): rdata_d = ext_corr_info_q;
				default: rdata_d = RST_WORD;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= RST_WORD;
		end else begin
			rdata_q <= reg_rd ? rdata_d : RST_WORD; // data only in the cycle after the strobe
		end
	end

	// outputs straight from storage
	assign reg_rdata = rdata_q;
	assign irq_o = irq_bus.irq;
	assign lane_map_chk_o = lane_map_q[4];
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lane_map_nib_o[i*DW +: DW] = lane_map_q[i];
		end
		for (int i = 0; i < N_GP; i++) begin
			gp_output_o[i*DW +: DW] = gp_out_q[i];
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	AST_INFO_WRITE_IGNORED: assert property (
		(reg_wr && hit(reg_addr, OFF_SRAM_CORR_LO) && !sram_corr_evt_i) |=> $stable(sram_corr_info_q))
		else $error("capture register changed by software write");

	AST_RW_READBACK: assert property (
		(reg_rd && hit(reg_addr, OFF_IRQ_SETUP)) |=> reg_rdata == $past(irq_setup_q))
		else $error("setup register did not read back stored value");

	AST_SETUP_STORE: assert property (
		(reg_wr && hit(reg_addr, OFF_IRQ_SETUP)) |=> irq_setup_q == $past(reg_wdata))
		else $error("setup register did not store written value");

	AST_RDATA_IDLE_ZERO: assert property (
		!reg_rd |=> reg_rdata == RST_WORD)
		else $error("read data present without a read strobe");

	AST_LANE_CHK_READBACK: assert property (
		(reg_rd && hit(reg_addr, OFF_LANE_CHECKBITS)) |=> reg_rdata == $past(lane_map_chk_o))
		else $error("check-bit lane map did not read back");

	AST_GP_READBACK: assert property (
		(reg_rd && hit(reg_addr, OFF_GP_OUT1)) |=> reg_rdata == $past(gp_output_o[63:32]))
		else $error("output word one did not read back");

	AST_TRAIN_LIVE: assert property (
		(reg_rd && hit(reg_addr, OFF_TRAIN_REQ)) |=> reg_rdata == $past(train_req_state_i))
		else $error("training request status not live");

	AST_UPD_LIVE: assert property (
		(reg_rd && hit(reg_addr, OFF_UPD_REQ)) |=> reg_rdata == $past(upd_req_state_i))
		else $error("update request status not live");

	AST_LANE_NIB_DRIVE: assert property (
		(reg_wr && hit(reg_addr, OFF_LANE_NIB_MID_LO)) |=> lane_map_nib_o[63:32] == $past(reg_wdata))
		else $error("nibble lane map not driven from written word");

	AST_LANE_NIB_LO_DRIVE: assert property (
		(reg_wr && hit(reg_addr, OFF_LANE_NIB_LO)) |=> lane_map_nib_o[31:0] == $past(reg_wdata))
		else $error("lowest nibble lane map not driven from written word");

	AST_LANE_NIB_HI_DRIVE: assert property (
		(reg_wr && hit(reg_addr, OFF_LANE_NIB_HI)) |=> lane_map_nib_o[127:96] == $past(reg_wdata))
		else $error("highest nibble lane map not driven from written word");

	AST_LANE_CHK_DRIVE: assert property (
		(reg_wr && hit(reg_addr, OFF_LANE_CHECKBITS)) |=> lane_map_chk_o == $past(reg_wdata))
		else $error("check-bit lane map not driven from written word");

	AST_RANK_LIVE: assert property (
		(reg_rd && hit(reg_addr, OFF_RANK_MODE)) |=> reg_rdata == $past(rank_mode_state_i))
		else $error("rank state not live");

	AST_SEQ_LIVE: assert property (
		(reg_rd && hit(reg_addr, OFF_SEQ_PROGRESS)) |=> reg_rdata == $past(seq_progress_i))
		else $error("sequence progress not live");

	AST_GP_INPUT_LIVE: assert property (
		(reg_rd && hit(reg_addr, OFF_GP_INPUT)) |=> reg_rdata == $past(gp_input_i))
		else $error("general input view not live");

	AST_GP_OUT0_DRIVE: assert property (
		(reg_wr && hit(reg_addr, OFF_GP_OUT0)) |=> gp_output_o[31:0] == $past(reg_wdata))
		else $error("output word zero not driven from written word");

	AST_GP_OUT_DRIVE: assert property (
		(reg_wr && hit(reg_addr, OFF_GP_OUT3)) |=> gp_output_o[127:96] == $past(reg_wdata))
		else $error("output word three not driven from written word");

	AST_CLEAR_READS_ZERO: assert property (
		(reg_rd && hit(reg_addr, OFF_IRQ_CLEAR)) |=> reg_rdata == 32'h00000000)
		else $error("clear register returned data");

	AST_RAW_AFTER_EVENT: assert property (
		ext_corr_evt_i |=> irq_bus.raw[IRQ_EXT_CORR])
		else $error("raw status bit missing after event");

	AST_RAW_READ: assert property (
		(reg_rd && hit(reg_addr, OFF_IRQ_RAW)) |=> reg_rdata == {{(DW-N_SRC){1'b0}}, $past(irq_bus.raw)})
		else $error("raw status read disagrees with sticky bits");

	AST_INFO_CAPTURE: assert property (
		sram_defer_evt_i |=> sram_defer_info_q == $past(sram_defer_info_i))
		else $error("deferred error details not captured");

	AST_CORR_CAPTURE: assert property (
		sram_corr_evt_i |=> sram_corr_info_q == $past(sram_corr_info_i))
		else $error("corrected error details not captured");

	AST_EXT_CAPTURE: assert property (
		ext_corr_evt_i |=> ext_corr_info_q == $past(ext_corr_info_i))
		else $error("external error details not captured");

	AST_DEFER_HI_READ: assert property (
		(reg_rd && hit(reg_addr, OFF_SRAM_DEFER_HI)) |=> reg_rdata == $past(sram_defer_info_q[63:32]))
		else $error("deferred error upper word read wrong");

	AST_DEFER_LO_READ: assert property (
		(reg_rd && hit(reg_addr, OFF_SRAM_DEFER_LO)) |=> reg_rdata == $past(sram_defer_info_q[31:0]))
		else $error("deferred error lower word read wrong");

	AST_CORR_LO_READ: assert property (
		(reg_rd && hit(reg_addr, OFF_SRAM_CORR_LO)) |=> reg_rdata == $past(sram_corr_info_q[31:0]))
		else $error("corrected error lower word read wrong");

	AST_CORR_HI_READ: assert property (
		(reg_rd && hit(reg_addr, OFF_SRAM_CORR_HI)) |=> reg_rdata == $past(sram_corr_info_q[63:32]))
		else $error("corrected error upper word read wrong");

	AST_EXT_READ: assert property (
		(reg_rd && hit(reg_addr, OFF_EXT_CORR_LO)) |=> reg_rdata == $past(ext_corr_info_q))
		else $error("external error word read wrong");

	AST_EXT_WRITE_IGNORED: assert property (
		(reg_wr && hit(reg_addr, OFF_EXT_CORR_LO) && !ext_corr_evt_i) |=> $stable(ext_corr_info_q))
		else $error("external capture register changed by software write");

endmodule // msr_regbank

`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the status, lane-map, user word and interrupt register bank
`timescale 1ns/100ps
`default_nettype none

module testbench;
	import msr_pkg::*;
	logic ref_clk, rstn, reg_wr, reg_rd, se0, se1, se2, irq_o;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, tr, up, rk, sq, gi, ei, lck, seed;
	logic [63:0] i0, i1;
	logic [127:0] lnib, gpo;
	int miscompares, n_tests;
	// behavioural model: stored words, sticky bits, captured details
	logic [31:0] rw_m [int];
	logic [63:0] info_m [3];
	logic [2:0] raw_m;
	int rwo [$] = '{OFF_LANE_NIB_LO, OFF_LANE_NIB_MID_LO, OFF_LANE_NIB_MID_HI, OFF_LANE_NIB_HI,
		OFF_LANE_CHECKBITS, OFF_GP_OUT0, OFF_GP_OUT1, OFF_GP_OUT2, OFF_GP_OUT3, OFF_IRQ_SETUP};
	int offs [$] = '{OFF_TRAIN_REQ, OFF_UPD_REQ, OFF_RANK_MODE, OFF_SEQ_PROGRESS, OFF_GP_INPUT,
		OFF_IRQ_CLEAR, OFF_IRQ_RAW, OFF_SRAM_CORR_LO, OFF_SRAM_CORR_HI, OFF_SRAM_DEFER_LO,
		OFF_SRAM_DEFER_HI, OFF_EXT_CORR_LO, 12'h394, 12'h404, 12'h50C, 12'h52C, 12'hFFC};

	msr_regbank #(.ADDR_W(12)) uut (
		.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .train_req_state_i(tr),
		.upd_req_state_i(up), .rank_mode_state_i(rk), .seq_progress_i(sq), .gp_input_i(gi),
		.sram_corr_evt_i(se0), .sram_corr_info_i(i0), .sram_defer_evt_i(se1),
		.sram_defer_info_i(i1), .ext_corr_evt_i(se2), .ext_corr_info_i(ei),
		.lane_map_nib_o(lnib), .lane_map_chk_o(lck), .gp_output_o(gpo), .irq_o(irq_o)
	);

	// clock at 100 MHz
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// shift register source of random words
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction

	// model state after any reset
	task automatic mreset();
		foreach (rwo[i]) rw_m[rwo[i]] = 32'h00000000;
		raw_m = 3'h0;
		foreach (info_m[i]) info_m[i] = 64'h0000000000000000;
	endtask

	// model of the read data for one offset
	function automatic logic [31:0] mrd(int a);
		if (rw_m.exists(a)) return rw_m[a];
		case (a)
			OFF_TRAIN_REQ: return tr;
			OFF_UPD_REQ: return up;
			OFF_RANK_MODE: return rk;
			OFF_SEQ_PROGRESS: return sq;
			OFF_GP_INPUT: return gi;
			OFF_IRQ_RAW: return {29'h0, raw_m};
			OFF_SRAM_CORR_LO: return info_m[0][31:0];
			OFF_SRAM_CORR_HI: return info_m[0][63:32];
			OFF_SRAM_DEFER_LO: return info_m[1][31:0];
			OFF_SRAM_DEFER_HI: return info_m[1][63:32];
			OFF_EXT_CORR_LO: return info_m[2][31:0];
			default: return 32'h00000000;
		endcase
	endfunction

	// word compare
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// interrupt level compare; an enable write reaches the level one edge late, so one edge passes first
	task automatic chk_irq();
		logic e;
		@(posedge ref_clk);
		#1;
		e = |(raw_m & rw_m[OFF_IRQ_SETUP][2:0]);
		n_tests++;
		if (irq_o !== e) begin
			miscompares++;
			$display("[ERR] irq_o expected %b seen %b", e, irq_o);
		end
	endtask

	// one write cycle, model follows at the taking edge
	task automatic wr(int a, logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a[11:0];
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		if (rw_m.exists(a)) rw_m[a] = d;
		if (a == OFF_IRQ_CLEAR) raw_m = raw_m & ~d[2:0];
		#1;
	endtask

	// one read cycle, data looked at in the following cycle only
	task automatic rd(int a);
		logic [31:0] e;
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a[11:0];
		@(posedge ref_clk);
		e = mrd(a);
		reg_rd <= 1'b0;
		#1;
		chk($sformatf("read %h", a[11:0]), e, reg_rdata);
	endtask

	task automatic rd_all();
		foreach (offs[i]) rd(offs[i]);
		foreach (rwo[i]) rd(rwo[i]);
	endtask

	// one-cycle error event with its details
	task automatic pulse(int s, logic [63:0] d);
		@(posedge ref_clk);
		{se2, se1, se0} <= 3'b001 << s;
		i0 <= d;
		i1 <= d;
		ei <= d[31:0];
		@(posedge ref_clk);
		{se2, se1, se0} <= 3'b000;
		#1;
		raw_m[s] = 1'b1;
		info_m[s] = d;
	endtask

	// stored words seen on the outputs
	task automatic chk_out();
		for (int n = 0; n < 4; n++) begin
			chk("lane_map_nib_o", rw_m[OFF_LANE_NIB_LO + 4 * n], lnib[32 * n +: 32]);
			chk("gp_output_o", rw_m[OFF_GP_OUT0 + 4 * n], gpo[32 * n +: 32]);
		end
		chk("lane_map_chk_o", rw_m[OFF_LANE_CHECKBITS], lck);
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		tally_and_finish();
	end

	// main sequence
	initial begin
		{reg_wr, reg_rd, se0, se1, se2} = 5'h00;
		{tr, up, rk, sq, gi, ei, reg_wdata} = '0;
		{i0, i1} = '0;
		reg_addr = 12'h000;
		rstn = 1'b0;
		seed = 32'h00000052;
		mreset();
		repeat (8) @(posedge ref_clk);
		rstn <= 1'b1;
		rd_all();
		chk_out();
		// random words everywhere, read-only and unmapped places ignore them
		for (int k = 0; k < 3; k++) begin
			foreach (offs[i]) wr(offs[i], rnd());
			foreach (rwo[i]) wr(rwo[i], rnd());
			@(posedge ref_clk);
			{tr, up, rk, sq, gi} <= {rnd(), rnd(), rnd(), rnd(), rnd()};
			#1;
			chk_out();
			rd_all();
		end
		// every source raised with all enables on, then cleared one by one
		wr(OFF_IRQ_SETUP, 32'h00000007);
		for (int s = 0; s < 3; s++) begin
			pulse(s, {rnd(), rnd()});
			chk_irq();
		end
		rd_all();
		for (int s = 0; s < 3; s++) begin
			wr(OFF_IRQ_CLEAR, 32'h00000001 << s);
			chk_irq();
			rd(OFF_IRQ_RAW);
		end
		// masking: raw bit set while its enable is off
		wr(OFF_IRQ_SETUP, 32'h00000000);
		pulse(1, {rnd(), rnd()});
		chk_irq();
		wr(OFF_IRQ_SETUP, 32'hFFFFFFF2);
		chk_irq();
		wr(OFF_IRQ_SETUP, 32'h00000005);
		chk_irq();
		rd(OFF_IRQ_RAW);
		// event and clear of the same bit together, event wins
		fork
			pulse(0, {rnd(), rnd()});
			wr(OFF_IRQ_CLEAR, 32'hFFFFFFFF);
		join
		chk_irq();
		rd_all();
		// second reset in mid-run
		@(posedge ref_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		mreset();
		rstn <= 1'b1;
		#1;
		chk_out();
		chk_irq();
		rd_all();
		tally_and_finish();
	end
endmodule // testbench

`default_nettype wire
